/* File: rtl/cfg_space_pkg.sv */
/*
 * Constants shared by the configuration command/status logic: byte offsets,
 * field positions, values after reset and the byte-lane mask helper.
 * Assumes configuration cycles arrive as dword accesses with byte enables.
 */
package cfg_space_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses in configuration space)
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h06;
    // Both registers share the dword at 04h
    localparam logic [5:0] CMD_STATUS_DWORD = 6'h01;

    // ----------------------------------------------------------------
    // Command register layout
    // ----------------------------------------------------------------
    localparam int CMD_IO_BIT = 0;
    localparam int CMD_MEM_BIT = 1;
    localparam int CMD_PER_BIT = 6;
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // Status register layout
    // ----------------------------------------------------------------
    localparam logic [15:0] STATUS_RESET = 16'h0210;
    // Bits 10-9 timing, bit 4 capability list, all other fixed bits zero
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic [7:0] STATUS_LOW_FIXED = 8'h10;
    localparam logic [15:0] STATUS_W1C_MASK = 16'hF800;
    // Flag vector order: {15,14,13,12,11,8}
    localparam int FLAG_COUNT = 6;
    localparam int FLAG_DET_PERR = 5;
    localparam int FLAG_SIG_SERR = 4;
    localparam int FLAG_MST_ABORT = 3;
    localparam int FLAG_RCV_TABORT = 2;
    localparam int FLAG_SIG_TABORT = 1;
    localparam int FLAG_DATA_PERR = 0;
    localparam logic [5:0] FLAG_RESET = 6'h00;

    // ----------------------------------------------------------------
    // Answer timing of a configuration access
    // ----------------------------------------------------------------
    localparam int CFG_ACK_CYCLES = 1;

    // Two byte enables widened to a 16-bit write mask
    function automatic logic [15:0] be_mask16(input logic [1:0] be);
        be_mask16 = {{8{be[1]}}, {8{be[0]}}};
    endfunction

endpackage

/* File: rtl/sticky_flags.sv */
/*
 * Sticky event flags: hardware sets, software clears with a one.
 * Assumes set and clear pulses come from logic on the same clock.
 */
`timescale 1ns/1ps
module sticky_flags #(
    parameter int W = 6,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Events and clears
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    // Flag state
    output logic [W-1:0] o_flags
);

    typedef struct packed {
        logic [W-1:0] flags;
    } flag_state_type;

    flag_state_type state_r;
    flag_state_type state_nxt;

    // Set beats clear so an event in the clearing cycle is kept
    always_comb begin
        state_nxt = state_r;
        state_nxt.flags = (state_r.flags & ~i_clr) | i_set;
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_r <= '{flags: RESET_VAL};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_flags = state_r.flags;

endmodule

/* File: rtl/space_gate.sv */
/*
 * Target decode gating by the memory and I/O space enables.
 * Assumes hit inputs come from the address comparators of the target.
 */
`timescale 1ns/1ps
module space_gate (
    // Space enables
    input wire logic i_mem_en,
    input wire logic i_io_en,
    // Decoded cycles
    input wire logic i_mem_hit,
    input wire logic i_mmio_hit,
    input wire logic i_io_hit,
    // Claims
    output logic o_mem_claim,
    output logic o_mmio_claim,
    output logic o_io_claim,
    output logic o_devsel
);

    // Handshake-level claims stay combinational to meet decode timing
    always_comb begin
        o_mem_claim = i_mem_en & i_mem_hit;
        o_mmio_claim = i_mem_en & i_mmio_hit;
        o_io_claim = i_io_en & i_io_hit;
        o_devsel = o_mem_claim | o_mmio_claim | o_io_claim;
    end

endmodule

/* File: rtl/cfg_cmd_status.sv */
/*
 * Configuration command/status block of the primary bus interface:
 * space enables that gate target claims and the error/capability status.
 * Assumes configuration accesses and bus events arrive on I_REF_CLK from
 * the bus interface logic, so no input is resynchronised.
 */
// Function
// - Memory enable clear: no memory claim, no DEVSEL; set: memory claimed.
// - Memory enable also gates the card control memory-mapped window.
// - I/O enable resets 0; clear ignores I/O cycles, set claims them.
// - Status resets to 0210h; writing one clears bits 15-11, never sets.
// - Bit 15 sets on any parity error, regardless of response enable.
// - Bit 14 sets when SERR is driven; cleared by writing one.
// - Bits 13/12 set on own master-abort / received target-abort.
// - Bit 11 sets when the target ends a cycle with target-abort.
// - Bits 10-9 read fixed medium timing code 01b.
// - Bit 8 sets on PERR while master with parity response enabled.
// - Bit 7 reads zero, writes ignored.
// - Bit 6 reads zero, writes ignored.
// - Bit 5 reads zero, writes ignored.
// - Bit 4 reads one, capability list present.
// - Bits 3-0 read zero, writes ignored.
// - Parity response enable resets 0; gates PERR assertion and reporting.
`timescale 1ns/1ps
module cfg_cmd_status (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    // Configuration access
    input wire logic i_CFG_RD,
    input wire logic i_CFG_WR,
    input wire logic [5:0] i_CFG_DWORD,
    input wire logic [3:0] i_CFG_BE,
    input wire logic [31:0] i_CFG_WDATA,
    output logic [31:0] o_CFG_RDATA,
    output logic o_CFG_ACK,
    // Target decode
    input wire logic i_MEM_HIT,
    input wire logic i_MMIO_HIT,
    input wire logic i_IO_HIT,
    output logic o_MEM_CLAIM,
    output logic o_MMIO_CLAIM,
    output logic o_IO_CLAIM,
    output logic o_DEVSEL,
    // Bus events
    input wire logic i_PAR_ERR,
    input wire logic i_PERR_SEEN,
    input wire logic i_IS_MASTER,
    input wire logic i_SERR_DRIVEN,
    input wire logic i_MASTER_ABORT,
    input wire logic i_RCV_TARGET_ABORT,
    input wire logic i_SIG_TARGET_ABORT,
    // Parity reporting
    output logic o_PERR_ASSERT
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic io_en;
        logic mem_en;
        logic per_en;
        logic [31:0] rdata;
        logic ack;
        logic perr_out;
    } main_state_type;

    main_state_type state_r;
    main_state_type state_nxt;

    logic [5:0] flags;
    logic [5:0] flag_set;
    logic [5:0] flag_clr;
    logic [15:0] cmd_value;
    logic [15:0] status_value;
    logic hit_dword;
    logic [15:0] cmd_wmask;
    logic [15:0] st_wmask;
    logic [15:0] st_clear;

    // ----------------------------------------------------------------
    // Register views
    // ----------------------------------------------------------------
    // Unimplemented command bits read as zero
    always_comb begin
        cmd_value = cfg_space_pkg::CMD_RESET;
        cmd_value[cfg_space_pkg::CMD_IO_BIT] = state_r.io_en;
        cmd_value[cfg_space_pkg::CMD_MEM_BIT] = state_r.mem_en;
        cmd_value[cfg_space_pkg::CMD_PER_BIT] = state_r.per_en;
    end

    always_comb begin
        status_value = {flags[cfg_space_pkg::FLAG_DET_PERR],
                        flags[cfg_space_pkg::FLAG_SIG_SERR],
                        flags[cfg_space_pkg::FLAG_MST_ABORT],
                        flags[cfg_space_pkg::FLAG_RCV_TABORT],
                        flags[cfg_space_pkg::FLAG_SIG_TABORT],
                        cfg_space_pkg::DEVSEL_MEDIUM,
                        flags[cfg_space_pkg::FLAG_DATA_PERR],
                        cfg_space_pkg::STATUS_LOW_FIXED};
    end

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    // Only the dword holding command and status is mapped here
    always_comb begin
        hit_dword = (i_CFG_DWORD == cfg_space_pkg::CMD_STATUS_DWORD);
        cmd_wmask = cfg_space_pkg::be_mask16(i_CFG_BE[1:0]);
        st_wmask = cfg_space_pkg::be_mask16(i_CFG_BE[3:2]);
        // ones clear, only at writable flag positions
        st_clear = (i_CFG_WR && hit_dword) ?
                   (i_CFG_WDATA[31:16] & st_wmask &
                    cfg_space_pkg::STATUS_W1C_MASK) : 16'h0000;
    end

    // bit 8 never cleared by a write
    always_comb begin
        flag_clr = {st_clear[15], st_clear[14], st_clear[13],
                    st_clear[12], st_clear[11], 1'b0};
    end

    // ----------------------------------------------------------------
    // Event capture
    // ----------------------------------------------------------------
    always_comb begin
        flag_set = 6'h00;
        flag_set[cfg_space_pkg::FLAG_DET_PERR] = i_PAR_ERR;
        flag_set[cfg_space_pkg::FLAG_SIG_SERR] = i_SERR_DRIVEN;
        flag_set[cfg_space_pkg::FLAG_MST_ABORT] = i_MASTER_ABORT;
        flag_set[cfg_space_pkg::FLAG_RCV_TABORT] = i_RCV_TARGET_ABORT;
        flag_set[cfg_space_pkg::FLAG_SIG_TABORT] = i_SIG_TARGET_ABORT;
        flag_set[cfg_space_pkg::FLAG_DATA_PERR] =
            (i_PERR_SEEN | state_r.perr_out) & i_IS_MASTER & state_r.per_en;
    end

    // Sticky flags; set wins over a clear in the same cycle
    sticky_flags #(
        .W(cfg_space_pkg::FLAG_COUNT),
        .RESET_VAL(cfg_space_pkg::FLAG_RESET)
    ) u_flags (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RST_N),
        .i_set(flag_set),
        .i_clr(flag_clr),
        .o_flags(flags)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        state_nxt.ack = i_CFG_RD | i_CFG_WR;
        state_nxt.rdata = 32'h0000_0000;
        // PERR asserted only with response enabled
        state_nxt.perr_out = i_PAR_ERR & state_r.per_en;
        if (i_CFG_WR && hit_dword) begin
            if (cmd_wmask[cfg_space_pkg::CMD_MEM_BIT]) begin
                state_nxt.mem_en = i_CFG_WDATA[cfg_space_pkg::CMD_MEM_BIT];
            end
            if (cmd_wmask[cfg_space_pkg::CMD_IO_BIT]) begin
                state_nxt.io_en = i_CFG_WDATA[cfg_space_pkg::CMD_IO_BIT];
            end
            if (cmd_wmask[cfg_space_pkg::CMD_PER_BIT]) begin
                state_nxt.per_en = i_CFG_WDATA[cfg_space_pkg::CMD_PER_BIT];
            end
        end
        // Unmapped dwords read zero but are still answered
        if (i_CFG_RD && hit_dword) begin
            state_nxt.rdata = {status_value, cmd_value};
        end
    end

    // State register; enables clear at reset
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            state_r <= '{io_en: 1'b0, mem_en: 1'b0, per_en: 1'b0,
                         rdata: 32'h0000_0000, ack: 1'b0, perr_out: 1'b0};
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // claims gated by enables
    space_gate u_gate (
        .i_mem_en(state_r.mem_en),
        .i_io_en(state_r.io_en),
        .i_mem_hit(i_MEM_HIT),
        .i_mmio_hit(i_MMIO_HIT),
        .i_io_hit(i_IO_HIT),
        .o_mem_claim(o_MEM_CLAIM),
        .o_mmio_claim(o_MMIO_CLAIM),
        .o_io_claim(o_IO_CLAIM),
        .o_devsel(o_DEVSEL)
    );

    assign o_CFG_RDATA = state_r.rdata;
    assign o_CFG_ACK = state_r.ack;
    assign o_PERR_ASSERT = state_r.perr_out;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);

    sequence status_read_s;
        i_CFG_RD && hit_dword ##1 o_CFG_ACK;
    endsequence

    sequence w1c_no_set_s(int b);
        i_CFG_WR && hit_dword && i_CFG_BE[3] && i_CFG_WDATA[16 + b];
    endsequence

    mem_gate_a: assert property (
        i_MEM_HIT |-> o_MEM_CLAIM == state_r.mem_en)
        else $error("memory claim does not follow memory enable");

    mem_devsel_a: assert property (
        !state_r.mem_en && !o_IO_CLAIM |-> !o_DEVSEL)
        else $error("DEVSEL driven for a disabled memory cycle");

    mmio_gate_a: assert property (
        i_MMIO_HIT |-> o_MMIO_CLAIM == state_r.mem_en)
        else $error("card control window claim does not follow enable");

    io_gate_a: assert property (
        i_IO_HIT |-> o_IO_CLAIM == state_r.io_en)
        else $error("I/O claim does not follow I/O enable");

    reset_clear_a: assert property (
        !$past(I_RST_N) |->
            !state_r.io_en && !state_r.mem_en && !state_r.per_en)
        else $error("space enable set straight after reset");

    no_set_a: assert property (
        !i_SIG_TARGET_ABORT && !flags[cfg_space_pkg::FLAG_SIG_TABORT] |=>
            !flags[cfg_space_pkg::FLAG_SIG_TABORT])
        else $error("status flag set without an event");

    w1c_clear_a: assert property (
        (w1c_no_set_s(14) ##0 !i_SERR_DRIVEN) |=>
            !flags[cfg_space_pkg::FLAG_SIG_SERR])
        else $error("writing one did not clear flag 14");

    perr_set_a: assert property (
        i_PAR_ERR |=> flags[cfg_space_pkg::FLAG_DET_PERR])
        else $error("detected parity error flag not set");

    serr_set_a: assert property (
        i_SERR_DRIVEN |=> flags[cfg_space_pkg::FLAG_SIG_SERR])
        else $error("signaled system error flag not set");

    mabort_set_a: assert property (
        i_MASTER_ABORT |=> flags[cfg_space_pkg::FLAG_MST_ABORT])
        else $error("master abort flag not set");

    rabort_set_a: assert property (
        i_RCV_TARGET_ABORT |=> flags[cfg_space_pkg::FLAG_RCV_TABORT])
        else $error("received target abort flag not set");

    tabort_set_a: assert property (
        i_SIG_TARGET_ABORT |=> flags[cfg_space_pkg::FLAG_SIG_TABORT])
        else $error("signaled target abort flag not set");

    fixed_bits_a: assert property (
        status_read_s |-> o_CFG_RDATA[26:25] == 2'h1 &&
            o_CFG_RDATA[23:16] == 8'h10)
        else $error("fixed status bits read wrongly");

    dpd_cause_a: assert property (
        $rose(flags[cfg_space_pkg::FLAG_DATA_PERR]) |->
            $past(state_r.per_en) && $past(i_IS_MASTER) &&
            ($past(i_PERR_SEEN) || $past(o_PERR_ASSERT)))
        else $error("data parity flag set without its conditions");

    dpd_keep_a: assert property (
        flags[cfg_space_pkg::FLAG_DATA_PERR] |=>
            flags[cfg_space_pkg::FLAG_DATA_PERR])
        else $error("data parity flag cleared without reset");

    perr_gate_a: assert property (
        i_PAR_ERR && !state_r.per_en |=> !o_PERR_ASSERT)
        else $error("PERR asserted with response disabled");

    perr_on_a: assert property (
        i_PAR_ERR && state_r.per_en |=> o_PERR_ASSERT)
        else $error("PERR not asserted with response enabled");

endmodule

/* File: test/cfg_host_model.sv */
/*
 * Behavioural configuration host that issues single configuration
 * accesses to the command/status block.
 * Assumes the block answers exactly one cycle after taking a request.
 */
`timescale 1ns/1ps
module cfg_host_model (
    // Clock
    input wire logic i_clk,
    // Answer from the block
    input wire logic [31:0] i_rdata,
    input wire logic i_ack,
    // Request to the block
    output logic o_rd,
    output logic o_wr,
    output logic [5:0] o_dword,
    output logic [3:0] o_be,
    output logic [31:0] o_wdata
);
    // ----------------------------------------------------------------
    // Idle request lines
    // ----------------------------------------------------------------
    initial begin
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_dword = 6'h00;
        o_be = 4'h0;
        o_wdata = 32'h0000_0000;
    end

    // One access: request stands one edge, answer taken at the next edge
    task automatic access(input logic wr, input logic [5:0] dw,
            input logic [3:0] be, input logic [31:0] wd,
            output logic [31:0] rd, output logic ok);
        @(posedge i_clk);
        #1;
        o_rd = !wr;
        o_wr = wr;
        o_dword = dw;
        o_be = be;
        o_wdata = wd;
        @(posedge i_clk);
        #1;
        o_rd = 1'b0;
        o_wr = 1'b0;
        // Released data and byte-enable lines flip so a stale value never looks valid
        o_wdata = ~wd;
        o_be = ~be;
        // Answer stands until this edge; read before it updates
        @(posedge i_clk);
        ok = i_ack;
        rd = i_rdata;
    endtask

    task automatic clear_flags(input logic [15:0] mask, output logic ok);
        logic [31:0] rd;
        access(1'b1, 6'h01, 4'hC, {mask, 16'h0000}, rd, ok);
    endtask
endmodule

/* File: test/cfg_cmd_status_tb.sv */
/*
 * Self-checking bench for the command/status block with an integer
 * model of enables and sticky flags compared at every result.
 * Assumes the host model in cfg_host_model.sv drives the access port.
 */
`timescale 1ns/1ps
module cfg_cmd_status_tb;
    logic clk;
    logic rst_n;
    logic [5:0] ev; // Parity, seen, serr, m-abort, r-abort, s-abort
    logic master;
    logic [2:0] hit; // Io, mmio, mem
    logic [31:0] rdata, rd, seed;
    logic [31:0] wdata;
    logic rdq, wrq, ack, ok;
    logic [5:0] dword;
    logic [3:0] be;
    logic mclaim, xclaim, iclaim, devsel, perr;
    int n_fail, checks_done, cmd_m, flg_m;

    // ----------------------------------------------------------------
    // Clock, block and host
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    cfg_cmd_status cfg_cmd_status_i (.I_REF_CLK(clk), .I_RST_N(rst_n),
        .i_CFG_RD(rdq), .i_CFG_WR(wrq), .i_CFG_DWORD(dword), .i_CFG_BE(be),
        .i_CFG_WDATA(wdata), .o_CFG_RDATA(rdata), .o_CFG_ACK(ack),
        .i_MEM_HIT(hit[0]), .i_MMIO_HIT(hit[1]), .i_IO_HIT(hit[2]),
        .o_MEM_CLAIM(mclaim), .o_MMIO_CLAIM(xclaim), .o_IO_CLAIM(iclaim),
        .o_DEVSEL(devsel), .i_PAR_ERR(ev[5]), .i_PERR_SEEN(ev[4]),
        .i_IS_MASTER(master), .i_SERR_DRIVEN(ev[3]),
        .i_MASTER_ABORT(ev[2]), .i_RCV_TARGET_ABORT(ev[1]),
        .i_SIG_TARGET_ABORT(ev[0]), .o_PERR_ASSERT(perr));

    cfg_host_model cfg_host_model_i (.i_clk(clk), .i_rdata(rdata),
        .i_ack(ack), .o_rd(rdq), .o_wr(wrq), .o_dword(dword), .o_be(be),
        .o_wdata(wdata));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read command/status and compare with the model
    task automatic expect_regs();
        cfg_host_model_i.access(1'b0, 6'h01, 4'hF, 32'h0, rd, ok);
        chk({31'h0, ok}, 32'h1);
        chk(rd, {16'(flg_m) | 16'h0210, 16'(cmd_m)});
    endtask

    // Write, then follow the write in the model
    task automatic wr(input logic [5:0] dw, input logic [3:0] b,
            input logic [31:0] d);
        cfg_host_model_i.access(1'b1, dw, b, d, rd, ok);
        chk({31'h0, ok}, 32'h1);
        if (dw == 6'h01 && b[0]) cmd_m = int'(d[15:0] & 16'h0043);
        if (dw == 6'h01 && b[3]) flg_m = flg_m & ~(int'(d[31:27]) << 11);
    endtask

    task automatic clr(input logic [15:0] m);
        cfg_host_model_i.clear_flags(m, ok);
        chk({31'h0, ok}, 32'h1);
        flg_m = flg_m & ~(int'(m[15:11]) << 11);
    endtask

    // Random hits against the gated claims
    task automatic claims();
        logic [3:0] exp;
        @(posedge clk);
        #1;
        seed = lfsr(seed);
        hit = seed[2:0];
        #1;
        exp[0] = hit[0] & cmd_m[1];
        exp[1] = hit[1] & cmd_m[1];
        exp[2] = hit[2] & cmd_m[0];
        exp[3] = |exp[2:0];
        chk({28'h0, devsel, iclaim, xclaim, mclaim}, {28'h0, exp});
    endtask

    // All hits up while both enables are clear after reset
    task automatic quiet_claims();
        @(posedge clk);
        #1;
        hit = 3'h7;
        #1;
        chk({27'h0, perr, devsel, iclaim, xclaim, mclaim}, 32'h0);
    endtask

    // One-cycle event pulse with master level held afterwards
    task automatic pulse(input logic [5:0] e, input logic m);
        @(posedge clk);
        #1;
        ev = e;
        master = m;
        @(posedge clk);
        #1;
        ev = 6'h00;
        chk({31'h0, perr}, {31'h0, e[5] & cmd_m[6]});
        @(posedge clk);
        #1;
        flg_m = flg_m | (int'({e[5], e[3:0]}) << 11);
        if (cmd_m[6] && m && (e[4] || e[5])) flg_m = flg_m | 32'h100;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        ev = 6'h00;
        master = 1'b0;
        hit = 3'h7;
        seed = 32'd69047;
        cmd_m = 0;
        flg_m = 0;
        n_fail = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        quiet_claims();
        claims();
        expect_regs();
        // Fixed bits must shrug off ones
        wr(6'h01, 4'hF, 32'h07FF_0000);
        expect_regs();
        for (int i = 0; i < 8; i++) begin
            wr(6'h01, 4'h1, {25'h0, i[2], 4'h0, i[1:0]});
            claims();
            claims();
            expect_regs();
        end
        // Each flag set and seen, then bits 15-11 cleared; bit 8 stays set
        wr(6'h01, 4'h1, 32'h0000_0043);
        for (int i = 0; i < 6; i++) begin
            pulse(6'h01 << i, 1'b1);
            expect_regs();
            clr(16'hFF00);
            expect_regs();
        end
        wr(6'h01, 4'h1, 32'h0000_0003);
        pulse(6'h20, 1'b1);
        pulse(6'h18, 1'b0);
        expect_regs();
        clr(16'h4000);
        expect_regs();
        // Unmapped dword reads zero and drops writes
        wr(6'h02, 4'hF, 32'hFFFF_FFFF);
        cfg_host_model_i.access(1'b0, 6'h02, 4'hF, 32'h0, rd, ok);
        chk({31'h0, ok}, 32'h1);
        chk(rd, 32'h0);
        expect_regs();
        // Event and its clear in one cycle: the event wins
        fork
            clr(16'h0800);
            pulse(6'h01, 1'b0);
        join
        expect_regs();
        // Mid-run reset with every flag and enable set
        wr(6'h01, 4'h1, 32'h0000_0043);
        pulse(6'h3F, 1'b1);
        expect_regs();
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        cmd_m = 0;
        flg_m = 0;
        quiet_claims();
        expect_regs();
        repeat (300) begin
            seed = lfsr(seed);
            case (seed[1:0])
                2'h0: pulse(seed[7:2], seed[8]);
                2'h1: wr(6'h01, seed[11:8], lfsr(seed));
                2'h2: claims();
                default: expect_regs();
            endcase
        end
        expect_regs();
        results();
    end

    // Hang guard
    initial begin
        repeat (50000) @(posedge clk);
        n_fail++;
        results();
    end
endmodule
